// *** fcs_params.svh ***
// constants for the flash command sequencer
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH
`define FCS_UNLOCK1_ADDR  12'hAAA
`define FCS_UNLOCK2_ADDR  12'h554
`define FCS_UNLOCK1_DATA  8'hAA
`define FCS_UNLOCK2_DATA  8'h55
`define FCS_CMD_AUTOSEL   8'h90
`define FCS_CMD_PROGRAM   8'hA0
`define FCS_CMD_ERASE     8'h80
`define FCS_CMD_SECTOR    8'h30
`define FCS_CMD_BULK      8'h10
`define FCS_CMD_SUSPEND   8'hB0
`define FCS_CMD_RESUME    8'h30
`define FCS_CMD_RESET     8'hF0
`define FCS_CMD_BYPASS    8'h20
`define FCS_CMD_BYP_EXIT  8'h00
`define FCS_ID_OFS        8'h02
`define FCS_PROT_OFS      8'h04
`define FCS_MAIN_ID       16'h005A // arbitrary id value
`define FCS_REG_MAP       2'h0
`define FCS_REG_ID0       2'h1
`define FCS_REG_ID1       2'h2
`define FCS_MAP_PERIPH    7
`define FCS_MAIN_SZ       4'h5
`define FCS_SRAM_SZ       4'h3
`define FCS_BOOT_SZ       4'h2
`define FCS_BOOT_KIND     2'h0
`define FCS_CLK_MHZ       250
`define FCS_ERASE_WIN_US  80
`define FCS_ERASE_WIN_CYC (`FCS_ERASE_WIN_US * `FCS_CLK_MHZ)
`define FCS_BYTE_TMO_CYC  1024
`define FCS_PROG_CYC      64
`define FCS_ERASE_CYC     4096
`endif

// *** fcs_pkg.sv ***
// types of the flash command sequencer
package fcs_pkg;
  typedef enum logic [3:0] {
    FCS_READ    = 4'h0,
    FCS_U1      = 4'h1,
    FCS_U2      = 4'h2,
    FCS_AUTO    = 4'h3,
    FCS_PROG    = 4'h4,
    FCS_E1      = 4'h5,
    FCS_E2      = 4'h6,
    FCS_E3      = 4'h7,
    FCS_COLLECT = 4'h8,
    FCS_BYPASS  = 4'h9,
    FCS_BYPPROG = 4'hA,
    FCS_BYPRST  = 4'hB
  } fcs_cmd_e;

  typedef enum logic [2:0] {
    FCS_OP_IDLE  = 3'h0,
    FCS_OP_PROG  = 3'h1,
    FCS_OP_ERASE = 3'h2,
    FCS_OP_SUSP  = 3'h3,
    FCS_OP_SPROG = 3'h4
  } fcs_op_e;

  typedef struct packed {
    fcs_cmd_e    st;
    logic        boot_tgt;
    logic        byp;
    logic [7:0]  sec_mask;
    logic [17:0] waddr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [7:0]  csr_rdata;
    logic [7:0]  map;
    logic        rb;
    logic        p_start;
    logic        e_start;
    logic        susp;
    logic        resume;
    logic        prog_stb;
    logic        erase_stb;
    logic [4:0]  allow;
  } fcs_top_s;

  typedef struct packed {
    fcs_op_e     st;
    logic [19:0] ecnt;
    logic [19:0] pcnt;
    logic        prog_done;
    logic        erase_done;
  } fcs_op_s;

  typedef struct packed {
    logic [15:0] cnt;
    logic        expired;
  } fcs_tmr_s;
endpackage

// *** fcs_op_if.sv ***
// handshake between command decoder and operation timer
`timescale 1ns/100ps
interface fcs_op_if;
  logic start_prog;
  logic start_erase;
  logic suspend;
  logic resume;
  logic busy;
  logic erasing;
  logic suspended;
  logic prog_done;
  logic erase_done;
  modport dec (output start_prog, start_erase, suspend, resume,
               input  busy, erasing, suspended, prog_done, erase_done);
  modport eng (input  start_prog, start_erase, suspend, resume,
               output busy, erasing, suspended, prog_done, erase_done);
endinterface

// *** fcs_timer.sv ***
// restartable cycle counter with sticky expiry
`timescale 1ns/100ps
module fcs_timer
  import fcs_pkg::*;
#(
  parameter logic [15:0] LIMIT = 16'h0400
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic restart,
  input  wire logic run,
  output logic      expired
);
  fcs_tmr_s s_r, s_nxt;

  // count only while armed; restart always wins
  always_comb begin
    s_nxt = s_r;
    if (restart || !run) begin
      s_nxt = '0;
    end else if (!s_r.expired) begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
      if (s_r.cnt == LIMIT - 16'h0001) begin
        s_nxt.expired = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign expired = s_r.expired;
endmodule

// *** fcs_op_engine.sv ***
// program and erase duration timer with erase suspend
`timescale 1ns/100ps
module fcs_op_engine
  import fcs_pkg::*;
#(
  parameter logic [19:0] PROG_CYC  = 20'd64,
  parameter logic [19:0] ERASE_CYC = 20'd4096
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  fcs_op_if.eng     op
);
  fcs_op_s s_r, s_nxt;

  // erase count freezes while suspended so resume continues it
  always_comb begin
    s_nxt = s_r;
    s_nxt.prog_done = 1'b0;
    s_nxt.erase_done = 1'b0;
    case (s_r.st)
      FCS_OP_IDLE: begin
        if (op.start_prog) begin
          s_nxt.st = FCS_OP_PROG;
          s_nxt.pcnt = PROG_CYC;
        end else if (op.start_erase) begin
          s_nxt.st = FCS_OP_ERASE;
          s_nxt.ecnt = ERASE_CYC;
        end
      end
      FCS_OP_PROG, FCS_OP_SPROG: begin
        s_nxt.pcnt = s_r.pcnt - 20'd1;
        if (s_r.pcnt == 20'd1) begin
          s_nxt.prog_done = 1'b1;
          s_nxt.st = (s_r.st == FCS_OP_SPROG) ? FCS_OP_SUSP : FCS_OP_IDLE;
        end
      end
      FCS_OP_ERASE: begin
        s_nxt.ecnt = s_r.ecnt - 20'd1;
        if (op.suspend) begin
          s_nxt.st = FCS_OP_SUSP;
        end else if (s_r.ecnt == 20'd1) begin
          s_nxt.erase_done = 1'b1;
          s_nxt.st = FCS_OP_IDLE;
        end
      end
      FCS_OP_SUSP: begin
        if (op.resume) begin
          s_nxt.st = FCS_OP_ERASE;
        end else if (op.start_prog) begin
          s_nxt.st = FCS_OP_SPROG;
          s_nxt.pcnt = PROG_CYC;
        end
      end
      default: s_nxt.st = FCS_OP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign op.busy = (s_r.st == FCS_OP_PROG) || (s_r.st == FCS_OP_ERASE)
                   || (s_r.st == FCS_OP_SPROG);
  assign op.erasing = (s_r.st == FCS_OP_ERASE);
  assign op.suspended = (s_r.st == FCS_OP_SUSP) || (s_r.st == FCS_OP_SPROG);
  assign op.prog_done = s_r.prog_done;
  assign op.erase_done = s_r.erase_done;
endmodule

// *** fcs_top.sv ***
// flash command sequencer: bus command decoder, mapping and id registers
// Behaviour
// R01 - main flash eight 64KB sectors, boot flash four 8KB sectors
// R02 - per-sector protection; protected sectors refuse program and erase
// R03 - erase whole sectors only; program one word per operation
// R04 - sector erase can be suspended, other sectors read, then resumed
// R05 - ready/busy low while program or erase runs, high otherwise
// R06 - one select input per main sector and per boot sector
// R07 - plain bus writes never store data into flash
// R08 - host polls status or ready/busy after a program command
// R09 - bytes decoded in turn; execute only when complete without timeout
// R10 - invalid byte or inter-byte timeout returns to read array mode; code returns to bypass mode instead while bypass is active
// R11 - commands open with AAh at AAAh then 55h at 554h
// R12 - bypass mode accepts commands without the unlock writes
// R13 - address bits A15-A12 ignored when matching command cycles
// R14 - host asserts a sector select of the target on each command write
// R15 - any main select routes to main flash, any boot select to boot
// R16 - both arrays share commands; identifier read only on main flash
// R17 - some commands end in a read returning id or protection status
// R18 - map bits 0-4 allow fetch and data-read paths in split-space mode
// R19 - reset loads map bits 1-4 from config, clears 0 and 7
// R20 - map bit 7 enables port F peripheral mode
// R21 - first id register: main flash size low, sram size high nibble
// R22 - second id register: boot size bits 3:0, type bits 5:4
// R23 - after reset the decoder is in read array mode
// R24 - only A11-A0 compared for unlock and command addresses
// R25 - extra sector erase within 80us window, else erase starts
// R26 - bypass entered by 20h, program A0h plus data, left by 90h 00h
// R27 - inter-byte timeout is a restartable counter with parameter limit
// R28 - map bits 5 and 6 ignore writes and read zero
`timescale 1ns/100ps
`include "fcs_params.svh"
module fcs_top
  import fcs_pkg::*;
#(
  parameter int unsigned BYTE_TMO_CYC = `FCS_BYTE_TMO_CYC,
  parameter int unsigned ERASE_WIN_CYC = `FCS_ERASE_WIN_CYC,
  parameter logic [19:0] PROG_CYC = 20'd`FCS_PROG_CYC,
  parameter logic [19:0] ERASE_CYC = 20'd`FCS_ERASE_CYC,
  parameter logic [15:0] MAIN_ID = `FCS_MAIN_ID
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [15:0] bus_addr,
  input  wire logic [15:0] bus_wdata,
  output logic      [15:0] bus_rdata,
  input  wire logic [7:0]  main_sector_select,
  input  wire logic [3:0]  boot_sector_select,
  input  wire logic [7:0]  main_sector_protect,
  input  wire logic [3:0]  boot_sector_protect,
  input  wire logic [15:0] array_rdata,
  output logic             arr_prog_stb,
  output logic             arr_erase_stb,
  output logic             arr_boot,
  output logic      [7:0]  arr_sec_mask,
  output logic      [17:0] arr_waddr,
  output logic      [15:0] arr_wdata,
  output logic             ready_busy_pin,
  input  wire logic        csr_wr,
  input  wire logic        csr_rd,
  input  wire logic [1:0]  csr_addr,
  input  wire logic [7:0]  csr_wdata,
  output logic      [7:0]  csr_rdata,
  input  wire logic [3:0]  map_config,
  input  wire logic        split_space_mode,
  output logic             sram_fetch_allow,
  output logic             boot_fetch_allow,
  output logic             main_flash_fetch_allow,
  output logic             boot_data_read_allow,
  output logic             main_flash_data_read_allow,
  output logic             port_f_periph_mode
);
  fcs_top_s s_r, s_nxt;
  fcs_op_if op ();

  logic       hit_main;
  logic       hit_boot;
  logic       sel_prot;
  logic [7:0] sel_mask;
  logic [7:0] prot_all;
  logic [2:0] sec_idx;
  logic [17:0] cur_waddr;
  logic [7:0] wbyte;
  logic [11:0] a_low;
  logic       is_u1;
  logic       is_u2;
  logic       in_seq;
  logic       wr_hit;
  logic       byte_tmo;
  logic       win_tmo;
  logic       win_restart;

  // R15 route by sector selects; R06 one select per sector
  assign hit_main = |main_sector_select;
  assign hit_boot = |boot_sector_select;
  assign wr_hit = bus_wr && (hit_main || hit_boot);
  assign sel_mask = hit_main ? main_sector_select : {4'h0, boot_sector_select};
  assign prot_all = hit_main ? main_sector_protect : {4'h0, boot_sector_protect};
  // R02 protection of the addressed sector
  assign sel_prot = |(sel_mask & prot_all);
  assign wbyte = bus_wdata[7:0];
  // R13 R24 upper nibble ignored, only A11-A0 compared
  assign a_low = bus_addr[11:0];
  // R11 unlock pair
  assign is_u1 = (a_low == `FCS_UNLOCK1_ADDR) && (wbyte == `FCS_UNLOCK1_DATA);
  assign is_u2 = (a_low == `FCS_UNLOCK2_ADDR) && (wbyte == `FCS_UNLOCK2_DATA);
  assign in_seq = (s_r.st != FCS_READ) && (s_r.st != FCS_AUTO)
                  && (s_r.st != FCS_BYPASS);

  // lowest active select picks the sector index
  always_comb begin
    sec_idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (sel_mask[i]) begin
        sec_idx = 3'(i);
      end
    end
  end

  // R01 word address: sector index above the in-sector word offset
  assign cur_waddr = hit_main ? {sec_idx, bus_addr[15:1]}
                              : {3'h0, sec_idx, bus_addr[12:1]};

  // R09 R27 inter-byte timeout, restarted by every accepted write
  fcs_timer #(.LIMIT(16'(BYTE_TMO_CYC))) u_byte_tmr (
    .ref_clk (ref_clk),
    .rst     (rst),
    .restart (wr_hit),
    .run     (in_seq),
    .expired (byte_tmo)
  );

  // R25 multi-sector collection window
  fcs_timer #(.LIMIT(16'(ERASE_WIN_CYC))) u_win_tmr (
    .ref_clk (ref_clk),
    .rst     (rst),
    .restart (win_restart),
    .run     (s_r.st == FCS_COLLECT),
    .expired (win_tmo)
  );

  assign win_restart = wr_hit && (wbyte == `FCS_CMD_SECTOR)
                       && ((s_r.st == FCS_E3) || (s_r.st == FCS_COLLECT));

  fcs_op_engine #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) u_engine (
    .ref_clk (ref_clk),
    .rst     (rst),
    .op      (op.eng)
  );

  assign op.start_prog = s_r.p_start;
  assign op.start_erase = s_r.e_start;
  assign op.suspend = s_r.susp;
  assign op.resume = s_r.resume;

  // command decoder, register file and read data
  always_comb begin
    s_nxt = s_r;
    s_nxt.p_start = 1'b0;
    s_nxt.e_start = 1'b0;
    s_nxt.susp = 1'b0;
    s_nxt.resume = 1'b0;
    // R07 array changes only when a completed operation commits
    s_nxt.prog_stb = op.prog_done;
    s_nxt.erase_stb = op.erase_done;
    // R05 busy drives the pin low
    s_nxt.rb = ~op.busy;
    if (s_r.erase_stb) begin
      s_nxt.sec_mask = 8'h00;
    end
    // R10 timeout abandons the sequence
    if (byte_tmo && in_seq && s_r.st != FCS_COLLECT) begin
      s_nxt.st = s_r.byp ? FCS_BYPASS : FCS_READ;
    end else if (win_tmo && s_r.st == FCS_COLLECT) begin
      // R25 window closed: erase what was collected
      s_nxt.e_start = |s_r.sec_mask;
      s_nxt.st = FCS_READ;
    end else if (wr_hit && op.busy) begin
      // R04 only suspend is heard while an erase runs
      if (op.erasing && wbyte == `FCS_CMD_SUSPEND) begin
        s_nxt.susp = 1'b1;
      end
    end else if (wr_hit && op.suspended && s_r.st == FCS_READ
                 && wbyte == `FCS_CMD_RESUME) begin
      // R04 resume continues the frozen erase
      s_nxt.resume = 1'b1;
    end else if (wr_hit) begin
      // R09 one byte decoded per write, nothing buffered
      case (s_r.st)
        FCS_READ: begin
          if (is_u1) begin
            s_nxt.st = FCS_U1;
            s_nxt.boot_tgt = ~hit_main;
          end
        end
        FCS_U1: s_nxt.st = is_u2 ? FCS_U2 : FCS_READ;
        FCS_U2: begin
          s_nxt.st = FCS_READ;
          if (a_low == `FCS_UNLOCK1_ADDR) begin
            case (wbyte)
              `FCS_CMD_AUTOSEL: s_nxt.st = FCS_AUTO;
              `FCS_CMD_PROGRAM: s_nxt.st = FCS_PROG;
              `FCS_CMD_ERASE:   s_nxt.st = op.suspended ? FCS_READ : FCS_E1;
              // R26 R12 enter bypass
              `FCS_CMD_BYPASS: begin
                s_nxt.st = FCS_BYPASS;
                s_nxt.byp = 1'b1;
              end
              default: s_nxt.st = FCS_READ;
            endcase
          end
        end
        FCS_AUTO: begin
          if (wbyte == `FCS_CMD_RESET) begin
            s_nxt.st = FCS_READ;
          end
        end
        FCS_PROG, FCS_BYPPROG: begin
          s_nxt.st = s_r.byp ? FCS_BYPASS : FCS_READ;
          // R02 R03 one word, protected or erasing sector refused
          if (!sel_prot && !(op.suspended && |(sel_mask & s_r.sec_mask)
                             && (s_r.boot_tgt == ~hit_main))) begin
            s_nxt.p_start = 1'b1;
            s_nxt.waddr = cur_waddr;
            s_nxt.wdata = bus_wdata;
            s_nxt.boot_tgt = ~hit_main;
          end
        end
        FCS_E1: s_nxt.st = is_u1 ? FCS_E2 : FCS_READ;
        FCS_E2: s_nxt.st = is_u2 ? FCS_E3 : FCS_READ;
        FCS_E3: begin
          s_nxt.st = FCS_READ;
          s_nxt.boot_tgt = ~hit_main;
          if (wbyte == `FCS_CMD_SECTOR) begin
            // R03 whole sectors; R02 protected ones skipped
            s_nxt.sec_mask = sel_mask & ~prot_all;
            s_nxt.st = FCS_COLLECT;
          end else if (wbyte == `FCS_CMD_BULK
                       && a_low == `FCS_UNLOCK1_ADDR) begin
            s_nxt.sec_mask = (hit_main ? 8'hFF : 8'h0F) & ~prot_all;
            s_nxt.e_start = 1'b1;
          end
        end
        FCS_COLLECT: begin
          // R25 another sector inside the window
          if (wbyte == `FCS_CMD_SECTOR && s_r.boot_tgt == ~hit_main) begin
            s_nxt.sec_mask = s_r.sec_mask | (sel_mask & ~prot_all);
          end else begin
            s_nxt.st = FCS_READ;
            s_nxt.sec_mask = 8'h00;
          end
        end
        FCS_BYPASS: begin
          if (wbyte == `FCS_CMD_PROGRAM) begin
            s_nxt.st = FCS_BYPPROG;
          end else if (wbyte == `FCS_CMD_AUTOSEL) begin
            s_nxt.st = FCS_BYPRST;
          end
        end
        FCS_BYPRST: begin
          // R26 90h then 00h leaves bypass
          if (wbyte == `FCS_CMD_BYP_EXIT) begin
            s_nxt.st = FCS_READ;
            s_nxt.byp = 1'b0;
          end else begin
            s_nxt.st = FCS_BYPASS;
          end
        end
        default: s_nxt.st = FCS_READ;
      endcase
    end
    // R17 R16 autoselect reads: id on main only, else protection
    if (bus_rd) begin
      s_nxt.rdata = array_rdata;
      if (s_r.st == FCS_AUTO && s_r.boot_tgt == ~hit_main) begin
        if (bus_addr[7:0] == `FCS_ID_OFS && !s_r.boot_tgt) begin
          s_nxt.rdata = MAIN_ID;
        end else if (bus_addr[7:0] == `FCS_PROT_OFS) begin
          s_nxt.rdata = {15'h0000, sel_prot};
        end
      end
    end
    // R20 R28 map writes; bits 5 and 6 stay zero
    if (csr_wr && csr_addr == `FCS_REG_MAP) begin
      s_nxt.map = {csr_wdata[7], 2'b00, csr_wdata[4:0]};
    end
    // R21 R22 identification registers
    if (csr_rd) begin
      case (csr_addr)
        `FCS_REG_MAP: s_nxt.csr_rdata = s_r.map;
        `FCS_REG_ID0: s_nxt.csr_rdata = {`FCS_SRAM_SZ, `FCS_MAIN_SZ};
        `FCS_REG_ID1: s_nxt.csr_rdata = {2'b00, `FCS_BOOT_KIND, `FCS_BOOT_SZ};
        default:      s_nxt.csr_rdata = 8'h00;
      endcase
    end
    // R18 R19 paths gated only in split-space mode
    s_nxt.allow = split_space_mode ? s_nxt.map[4:0] : 5'h1F;
  end

  // R23 R19 reset to read array, map from configuration
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= FCS_READ;
      s_r.rb <= 1'b1;
      s_r.map <= {3'b000, map_config, 1'b0};
      s_r.allow <= 5'h1F;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus_rdata = s_r.rdata;
  assign csr_rdata = s_r.csr_rdata;
  assign ready_busy_pin = s_r.rb;
  assign arr_prog_stb = s_r.prog_stb;
  assign arr_erase_stb = s_r.erase_stb;
  assign arr_boot = s_r.boot_tgt;
  assign arr_sec_mask = s_r.sec_mask;
  assign arr_waddr = s_r.waddr;
  assign arr_wdata = s_r.wdata;
  assign sram_fetch_allow = s_r.allow[0];
  assign boot_fetch_allow = s_r.allow[1];
  assign main_flash_fetch_allow = s_r.allow[2];
  assign boot_data_read_allow = s_r.allow[3];
  assign main_flash_data_read_allow = s_r.allow[4];
  assign port_f_periph_mode = s_r.map[`FCS_MAP_PERIPH];
endmodule

// *** fcs_top_asserts.sv ***
// concurrent checks on the sequencer ports
`timescale 1ns/100ps
module fcs_top_asserts (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        bus_rd,
  input wire logic [15:0] bus_rdata,
  input wire logic        csr_rd,
  input wire logic [1:0]  csr_addr,
  input wire logic [7:0]  csr_rdata,
  input wire logic        split_space_mode,
  input wire logic        arr_prog_stb,
  input wire logic        arr_erase_stb,
  input wire logic        ready_busy_pin,
  input wire logic        sram_fetch_allow,
  input wire logic        boot_fetch_allow,
  input wire logic        main_flash_fetch_allow,
  input wire logic        boot_data_read_allow,
  input wire logic        main_flash_data_read_allow
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [4:0] allow;
  // access paths gathered in map bit order
  assign allow = {main_flash_data_read_allow, boot_data_read_allow,
                  main_flash_fetch_allow, boot_fetch_allow, sram_fetch_allow};
  chk_reset_ready: assert property ($fell(rst) |-> ready_busy_pin && bus_rdata == 16'h0000)
    else $error("not idle at reset");
  chk_prog_pulse: assert property (arr_prog_stb |=> !arr_prog_stb)
    else $error("program strobe too long");
  chk_erase_pulse: assert property (arr_erase_stb |=> !arr_erase_stb)
    else $error("erase strobe too long");
  chk_one_commit: assert property (!(arr_prog_stb && arr_erase_stb))
    else $error("both strobes at once");
  chk_commit_busy: assert property (arr_prog_stb |-> !$past(ready_busy_pin))
    else $error("program strobe while ready");
  chk_map_reserved: assert property (csr_rd && csr_addr == 2'h0 |=> csr_rdata[6:5] == 2'h0)
    else $error("map bits 6:5 nonzero");
  chk_id_low: assert property (csr_rd && csr_addr == 2'h1 |=> csr_rdata == 8'h35)
    else $error("size id 0 wrong");
  chk_id_high: assert property (csr_rd && csr_addr == 2'h2 |=> csr_rdata == 8'h02)
    else $error("size id 1 wrong");
  chk_allow_open: assert property (!split_space_mode |=> allow == 5'h1F)
    else $error("paths gated outside split mode");
  chk_rdata_hold: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data moved without read");
  cover property (arr_prog_stb);
  cover property (arr_erase_stb);
  cover property ($fell(ready_busy_pin));
endmodule

// *** fcs_array_model.sv ***
// flash array model behind the sequencer
`timescale 1ns/100ps
module fcs_array_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  main_sector_select,
  input  wire logic [3:0]  boot_sector_select,
  input  wire logic        arr_prog_stb,
  input  wire logic        arr_erase_stb,
  input  wire logic        arr_boot,
  input  wire logic [7:0]  arr_sec_mask,
  input  wire logic [17:0] arr_waddr,
  input  wire logic [15:0] arr_wdata,
  output logic      [15:0] array_rdata
);
  logic [15:0] mem [logic [18:0]];
  logic [18:0] rkey;
  // eight main sectors; unselected bus toggles, never stale
  always_comb begin
    rkey = {|boot_sector_select, 3'h0, bus_addr[15:1]};
    for (int i = 0; i < 8; i++) if (main_sector_select[i]) rkey[17:15] = 3'(i);
    array_rdata = mem.exists(rkey) ? mem[rkey] : 16'hFFFF;
    if (!(|{main_sector_select, boot_sector_select})) array_rdata = {16{ref_clk}};
  end
  // change only on commit; erase takes whole sectors
  always @(posedge ref_clk) begin
    if (arr_prog_stb) mem[{arr_boot, arr_waddr}] = arr_wdata;
    if (arr_erase_stb)
      foreach (mem[k]) if (k[18] == arr_boot && arr_sec_mask[k[17:15]]) mem[k] = 16'hFFFF;
  end
endmodule

// *** flash_command_sequencer_tb_top.sv ***
// self-checking bench for the sequencer
`timescale 1ns/100ps
module flash_command_sequencer_tb_top;
  logic        ref_clk = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
  logic [15:0] bus_addr = 16'h0000, bus_wdata = 16'h0000, bus_rdata, array_rdata, arr_wdata;
  logic [7:0]  main_sector_select = 8'h00, main_sector_protect = 8'h00, arr_sec_mask;
  logic [3:0]  boot_sector_select = 4'h0, boot_sector_protect = 4'h0, map_config = 4'hA;
  logic        csr_wr = 1'b0, csr_rd = 1'b0, split_space_mode = 1'b0;
  logic [1:0]  csr_addr = 2'h0;
  logic [7:0]  csr_wdata = 8'h00, csr_rdata;
  logic [17:0] arr_waddr;
  logic        arr_prog_stb, arr_erase_stb, arr_boot, ready_busy_pin, port_f_periph_mode;
  logic        sram_fetch_allow, boot_fetch_allow, main_flash_fetch_allow;
  logic        boot_data_read_allow, main_flash_data_read_allow;
  wire  [4:0]  allow = {main_flash_data_read_allow, boot_data_read_allow,
                        main_flash_fetch_allow, boot_fetch_allow, sram_fetch_allow};
  int          mismatches = 0, num_checks = 0, cyc = 0, erases = 0;

  // short counts keep erase and timeout paths quick
  fcs_top #(.BYTE_TMO_CYC(16), .ERASE_WIN_CYC(32), .PROG_CYC(20'd8), .ERASE_CYC(20'd20)) dut (
    .ref_clk, .rst, .bus_wr, .bus_rd, .bus_addr, .bus_wdata, .bus_rdata,
    .main_sector_select, .boot_sector_select, .main_sector_protect, .boot_sector_protect,
    .array_rdata, .arr_prog_stb, .arr_erase_stb, .arr_boot, .arr_sec_mask, .arr_waddr,
    .arr_wdata, .ready_busy_pin, .csr_wr, .csr_rd, .csr_addr, .csr_wdata, .csr_rdata,
    .map_config, .split_space_mode, .sram_fetch_allow, .boot_fetch_allow,
    .main_flash_fetch_allow, .boot_data_read_allow, .main_flash_data_read_allow,
    .port_f_periph_mode);
  fcs_array_model u_arr (.ref_clk, .bus_addr, .main_sector_select, .boot_sector_select,
    .arr_prog_stb, .arr_erase_stb, .arr_boot, .arr_sec_mask, .arr_waddr, .arr_wdata,
    .array_rdata);

  always #2 ref_clk = ~ref_clk;
  // watchdog, erase counter
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (arr_erase_stb) erases <= erases + 1;
    if (cyc == 20000) begin
      mismatches++;
      final_report;
    end
  end

  task automatic final_report;
    if (mismatches == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // bus cycles one clock each, driven at the falling edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    bus_wr = 1'b1;
    bus_addr = a;
    bus_wdata = d;
    @(negedge ref_clk);
    bus_wr = 1'b0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [15:0] e);
    @(negedge ref_clk);
    bus_rd = 1'b1;
    bus_addr = a;
    @(negedge ref_clk);
    bus_rd = 1'b0;
    chk(bus_rdata, e);
  endtask
  task automatic cw(input logic [1:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    csr_wr = 1'b1;
    csr_addr = a;
    csr_wdata = d;
    @(negedge ref_clk);
    csr_wr = 1'b0;
  endtask
  task automatic cr(input logic [1:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    csr_rd = 1'b1;
    csr_addr = a;
    @(negedge ref_clk);
    csr_rd = 1'b0;
    chk(csr_rdata, e);
  endtask
  // unlock pair, high address bits set, select held
  task automatic cmd(input logic [15:0] c);
    wr(16'hFAAA, 16'h00AA);
    wr(16'h3554, 16'h0055);
    wr(16'h7AAA, c);
  endtask
  task automatic wait_rb(input logic lvl, input int lim);
    int n = 0;
    while (ready_busy_pin !== lvl && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    chk(ready_busy_pin, lvl);
  endtask

  initial begin
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    cr(2'h0, 8'h14);
    cr(2'h1, 8'h35);
    cr(2'h2, 8'h02);
    chk(ready_busy_pin, 1'b1);
    cw(2'h0, 8'hFF);
    cw(2'h1, 8'h00);
    cr(2'h0, 8'h9F);
    cr(2'h1, 8'h35);
    chk(port_f_periph_mode, 1'b1);
    split_space_mode = 1'b1;
    cw(2'h0, 8'h0A);
    @(negedge ref_clk);
    chk(allow, 5'h0A);
    chk(port_f_periph_mode, 1'b0);
    split_space_mode = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(allow, 5'h1F);
    // plain write, program, broken sequences, protection
    main_sector_select = 8'h02;
    wr(16'h0010, 16'h1234);
    rdc(16'h0010, 16'hFFFF);
    cmd(16'h00A0);
    wr(16'h0010, 16'h1234);
    wait_rb(1'b0, 10);
    wait_rb(1'b1, 40);
    rdc(16'h0010, 16'h1234);
    cmd(16'h0077);
    wr(16'h0020, 16'h5555);
    rdc(16'h0020, 16'hFFFF);
    wr(16'hFAAA, 16'h00AA);
    repeat (20) @(negedge ref_clk);
    wr(16'h3554, 16'h0055);
    wr(16'h7AAA, 16'h00A0);
    wr(16'h0020, 16'h4321);
    rdc(16'h0020, 16'hFFFF);
    main_sector_protect = 8'h02;
    cmd(16'h00A0);
    wr(16'h0030, 16'h0F0F);
    repeat (20) @(negedge ref_clk);
    rdc(16'h0030, 16'hFFFF);
    // identifier and protection reads
    cmd(16'h0090);
    rdc(16'hF002, 16'h005A);
    rdc(16'h0004, 16'h0001);
    main_sector_select = 8'h00;
    boot_sector_select = 4'h1;
    rdc(16'h0002, 16'hFFFF);
    wr(16'h0000, 16'h00F0);
    main_sector_select = 8'h02;
    boot_sector_select = 4'h0;
    main_sector_protect = 8'h00;
    rdc(16'h0010, 16'h1234);
    // bypass program, then exit
    cmd(16'h0020);
    wr(16'h0000, 16'h00A0);
    wr(16'h0040, 16'h0ABC);
    wait_rb(1'b0, 10);
    wait_rb(1'b1, 40);
    rdc(16'h0040, 16'h0ABC);
    wr(16'h0000, 16'h0090);
    wr(16'h0000, 16'h0000);
    wr(16'h0000, 16'h00A0);
    wr(16'h0050, 16'h0DEF);
    repeat (20) @(negedge ref_clk);
    rdc(16'h0050, 16'hFFFF);
    // boot routing
    main_sector_select = 8'h00;
    boot_sector_select = 4'h4;
    cmd(16'h00A0);
    wr(16'h0060, 16'h0777);
    wait_rb(1'b0, 10);
    wait_rb(1'b1, 40);
    chk(arr_boot, 1'b1);
    chk(arr_wdata, 16'h0777);
    // sector erase with suspend and resume
    boot_sector_select = 4'h0;
    main_sector_select = 8'h02;
    cmd(16'h0080);
    cmd(16'h0030);
    wait_rb(1'b0, 80);
    wr(16'h0000, 16'h00B0);
    repeat (30) @(negedge ref_clk);
    chk(erases, 0);
    main_sector_select = 8'h04;
    rdc(16'h0010, 16'hFFFF);
    main_sector_select = 8'h02;
    wr(16'h0000, 16'h0030);
    wait_rb(1'b0, 10);
    wait_rb(1'b1, 200);
    rdc(16'h0010, 16'hFFFF);
    chk(erases, 1);
    final_report;
  end
endmodule

bind fcs_top fcs_top_asserts u_chk (.ref_clk, .rst, .bus_rd, .bus_rdata, .csr_rd, .csr_addr,
  .csr_rdata, .split_space_mode, .arr_prog_stb, .arr_erase_stb, .ready_busy_pin,
  .sram_fetch_allow, .boot_fetch_allow, .main_flash_fetch_allow, .boot_data_read_allow,
  .main_flash_data_read_allow);
